// ### pgs_pkg.sv
// constants for the pin configuration and supply select block
`default_nettype none

package pgs_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam int          ADDR_W          = 9;
	localparam logic [8:0]  ADDR_PIN_CFG_01 = 9'h015;
	localparam logic [8:0]  ADDR_PIN_CFG_23 = 9'h016;
	localparam logic [8:0]  ADDR_PIN_CFG_4  = 9'h017;
	localparam logic [8:0]  ADDR_WAKE_SENSE = 9'h01c;
	localparam logic [8:0]  ADDR_MODE_BITS  = 9'h01d;
	localparam logic [8:0]  ADDR_OUT_FN_LO  = 9'h01e;
	localparam logic [8:0]  ADDR_OUT_FN_HI  = 9'h01f;
	localparam logic [8:0]  ADDR_BUCK_B     = 9'h020;
	localparam logic [8:0]  ADDR_BUCK_A     = 9'h021;
	localparam logic [7:0]  REG_RST         = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int NUM_PINS      = 5;
	localparam int CFG_NIB_W     = 4;
	localparam int CFG_FUNC_LSB  = 0;
	localparam int CFG_TYPE_BIT  = 2;
	localparam int CFG_WEN_BIT   = 3;
	localparam int OUT2_LSB      = 6;
	localparam int OUT1_LSB      = 3;
	localparam int OUT0_LSB      = 0;
	localparam int OUT4_LSB      = 3;
	localparam int OUT3_LSB      = 0;
	localparam int BK_VSRC_LSB   = 5;
	localparam int BK_CONF_BIT   = 3;
	localparam int BK_ESRC_LSB   = 1;
	localparam int BK_EN_BIT     = 0;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PF_SPECIAL    = 2'b00,
		PF_INPUT      = 2'b01,
		PF_OPEN_DRAIN = 2'b10,
		PF_PUSH_PULL  = 2'b11
	} pgs_pin_fn_t;

	typedef enum logic [2:0] {
		OF_STATIC = 3'b000,
		OF_FAULT  = 3'b001,
		OF_CLK32  = 3'b010,
		OF_SEQ    = 3'b011,
		OF_FWD_4  = 3'b100,
		OF_FWD_5  = 3'b101,
		OF_FWD_6  = 3'b110,
		OF_FWD_7  = 3'b111
	} pgs_out_fn_t;

	localparam logic [1:0] SRC_SEQ  = 2'b00;
	localparam logic [2:0] DEB_NONE = 3'b000;

	// ------------------------------------------------------------
	// debounce timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ    = 125;
	localparam int          DEB_CNT_W  = 27;
	localparam int unsigned DEB_T1_US  = 100;
	localparam int unsigned DEB_T2_US  = 1000;
	localparam int unsigned DEB_T3_US  = 10240;
	localparam int unsigned DEB_T4_US  = 51200;
	localparam int unsigned DEB_T5_US  = 256000;
	localparam int unsigned DEB_T6_US  = 512000;
	localparam int unsigned DEB_T7_US  = 1024000;
	localparam int unsigned DEB_CYC_1  = DEB_T1_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_2  = DEB_T2_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_3  = DEB_T3_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_4  = DEB_T4_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_5  = DEB_T5_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_6  = DEB_T6_US * CLK_MHZ;
	localparam int unsigned DEB_CYC_7  = DEB_T7_US * CLK_MHZ;

endpackage

`default_nettype wire

// ### pgs_debounce.sv
// single input debouncer with a run-time hold length
`default_nettype none

module pgs_debounce (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_sys_rst,
	input  wire logic                          i_enable,
	input  wire logic [pgs_pkg::DEB_CNT_W-1:0] i_limit,
	input  wire logic                          i_raw,
	output logic                               o_level
);

	logic [pgs_pkg::DEB_CNT_W-1:0] cnt_r;
	logic                          level_r;

	// ------------------------------------------------------------
	// hold counter
	// ------------------------------------------------------------
	// a new level is taken only after it stood for i_limit cycles
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cnt_r   <= '0;
			level_r <= 1'b0;
		end else if (!i_enable) begin
			cnt_r   <= '0;
			level_r <= i_raw;
		end else if (i_raw == level_r) begin
			cnt_r <= '0;
		end else if (cnt_r >= i_limit - 1'b1) begin
			cnt_r   <= '0;
			level_r <= i_raw;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign o_level = level_r;

	chk_hold_time: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		(i_enable && $past(i_enable) && cnt_r == '0
			&& level_r == $past(level_r) && i_raw != level_r
			&& i_limit > 2)
		|=> (o_level == $past(level_r)))
		else $error("debounced level changed before hold time");

endmodule

`default_nettype wire

// ### pgs_gpio_supply.sv
// pin configuration, output function mux and buck supply select
// ------------------------------------------------------------
// Operation
// - per-pin bit picks edge (0) or level (1) wakeup, bits 4:0.
// - static output function drives the mode bit as pin value.
// - other output functions use the mode bit as polarity, 1 high.
// - on an input pin the mode bit turns debouncing on.
// - pin 2 function field 7:6: static, fault, 32 kHz, sequencer.
// - pin 4 function field 4:3 decodes the same way.
// - pin 1 field: 100 forwards input 0, 110 input 2, 111 input 3.
// - pin 0 field: 101, 110, 111 forward inputs 1, 2, 3.
// - pin 3 field: 100, 101, 110 forward inputs 0, 1, 2.
// - buck voltage source field 6:5: sequencer or input pin 1..3.
// - active edge selects first voltage, passive edge the second.
// - enable source 2:1; active edge enables, passive edge disables.
// - bit 3 marks a supply default or sequenced and kept on.
// - bit 0 requests the buck on; sequencer orders switching.
// - in dual-phase the second enable bit has no own effect.
// - type bit sets input active level, 1 high, 0 low.
// - pin function 01 input, 10 open-drain, 11 push-pull.
// - shared 3-bit debounce time from none up to 1024 ms.
// ------------------------------------------------------------
`default_nettype none

module pgs_gpio_supply #(
	parameter int unsigned DEB_CYC_1 = pgs_pkg::DEB_CYC_1,
	parameter int unsigned DEB_CYC_2 = pgs_pkg::DEB_CYC_2,
	parameter int unsigned DEB_CYC_3 = pgs_pkg::DEB_CYC_3,
	parameter int unsigned DEB_CYC_4 = pgs_pkg::DEB_CYC_4,
	parameter int unsigned DEB_CYC_5 = pgs_pkg::DEB_CYC_5,
	parameter int unsigned DEB_CYC_6 = pgs_pkg::DEB_CYC_6,
	parameter int unsigned DEB_CYC_7 = pgs_pkg::DEB_CYC_7
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	input  wire logic [pgs_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic [7:0]                 i_reg_wdata,
	output logic      [7:0]                 o_reg_rdata,
	input  wire logic [2:0]                 i_debounce_sel,
	input  wire logic [4:0]                 i_pin_in,
	output logic      [4:0]                 o_pin_out,
	output logic      [4:0]                 o_pin_oe,
	output logic      [4:0]                 o_wake_req,
	input  wire logic                       i_supply_fault,
	input  wire logic                       i_clk_32k,
	input  wire logic [4:0]                 i_seq_pin_ctl,
	input  wire logic                       i_seq_volt_second_a,
	input  wire logic                       i_seq_volt_second_b,
	input  wire logic                       i_dual_phase,
	output logic                            o_buck_a_on,
	output logic                            o_buck_b_on,
	output logic                            o_buck_a_volt_second,
	output logic                            o_buck_b_volt_second,
	output logic                            o_buck_a_seq_config,
	output logic                            o_buck_b_seq_config
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic pin_is_input(input logic [1:0] fn,
		input int idx);
		// code 00 on even pins is a dedicated input function
		return (fn == pgs_pkg::PF_INPUT) ||
			(fn == pgs_pkg::PF_SPECIAL && (idx % 2) == 0);
	endfunction

	// returns {valid, source index} for the forwarding codes 1xx
	function automatic logic [3:0] fwd_source(input int idx,
		input logic [2:0] code);
		logic [3:0] r;
		r = 4'h0;
		unique case (idx)
			1: case (code)
				3'b100:  r = 4'h8;
				3'b110:  r = 4'ha;
				3'b111:  r = 4'hb;
				default: r = 4'h0;
			endcase
			0: case (code)
				3'b101:  r = 4'h9;
				3'b110:  r = 4'ha;
				3'b111:  r = 4'hb;
				default: r = 4'h0;
			endcase
			3: case (code)
				3'b100:  r = 4'h8;
				3'b101:  r = 4'h9;
				3'b110:  r = 4'ha;
				default: r = 4'h0;
			endcase
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	function automatic logic apply_pol(input logic val, input logic pol);
		return pol ? val : ~val;
	endfunction

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] pin_cfg_r [3];
	logic [7:0] wake_sense_r;
	logic [7:0] mode_bits_r;
	logic [7:0] out_fn_lo_r;
	logic [7:0] out_fn_hi_r;
	logic [7:0] buck_r [2];
	logic [7:0] rdata_r;

	logic [1:0] en_evt;
	logic [1:0] en_val;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			for (int k = 0; k < 3; k++) begin
				pin_cfg_r[k] <= pgs_pkg::REG_RST;
			end
			wake_sense_r <= pgs_pkg::REG_RST;
			mode_bits_r  <= pgs_pkg::REG_RST;
			out_fn_lo_r  <= pgs_pkg::REG_RST;
			out_fn_hi_r  <= pgs_pkg::REG_RST;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				pgs_pkg::ADDR_PIN_CFG_01: pin_cfg_r[0] <= i_reg_wdata;
				pgs_pkg::ADDR_PIN_CFG_23: pin_cfg_r[1] <= i_reg_wdata;
				pgs_pkg::ADDR_PIN_CFG_4:  pin_cfg_r[2] <= i_reg_wdata;
				pgs_pkg::ADDR_WAKE_SENSE: wake_sense_r <= i_reg_wdata;
				pgs_pkg::ADDR_MODE_BITS:  mode_bits_r  <= i_reg_wdata;
				pgs_pkg::ADDR_OUT_FN_LO:  out_fn_lo_r  <= i_reg_wdata;
				pgs_pkg::ADDR_OUT_FN_HI:  out_fn_hi_r  <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// a pin event in the same cycle as a host write wins the enable bit
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			buck_r[0] <= pgs_pkg::REG_RST;
			buck_r[1] <= pgs_pkg::REG_RST;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (i_reg_wr && i_reg_addr == (b == 0 ?
					pgs_pkg::ADDR_BUCK_A : pgs_pkg::ADDR_BUCK_B)) begin
					buck_r[b] <= i_reg_wdata;
				end
				if (en_evt[b]) begin
					buck_r[b][pgs_pkg::BK_EN_BIT] <= en_val[b];
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rdata_r <= pgs_pkg::REG_RST;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				pgs_pkg::ADDR_PIN_CFG_01: rdata_r <= pin_cfg_r[0];
				pgs_pkg::ADDR_PIN_CFG_23: rdata_r <= pin_cfg_r[1];
				pgs_pkg::ADDR_PIN_CFG_4:  rdata_r <= pin_cfg_r[2];
				pgs_pkg::ADDR_WAKE_SENSE: rdata_r <= wake_sense_r;
				pgs_pkg::ADDR_MODE_BITS:  rdata_r <= mode_bits_r;
				pgs_pkg::ADDR_OUT_FN_LO:  rdata_r <= out_fn_lo_r;
				pgs_pkg::ADDR_OUT_FN_HI:  rdata_r <= out_fn_hi_r;
				pgs_pkg::ADDR_BUCK_B:     rdata_r <= buck_r[1];
				pgs_pkg::ADDR_BUCK_A:     rdata_r <= buck_r[0];
				default:                  rdata_r <= 8'h00;
			endcase
		end
	end

	assign o_reg_rdata = rdata_r;

	// ------------------------------------------------------------
	// per-pin fields
	// ------------------------------------------------------------
	logic [1:0] pin_fn   [5];
	logic [2:0] out_fn   [5];
	logic [4:0] act_lvl;
	logic [4:0] wen_n;
	logic [4:0] is_in;
	logic [4:0] deb_lvl;
	logic [4:0] deb_en;
	logic [4:0] act;

	always_comb begin
		for (int i = 0; i < pgs_pkg::NUM_PINS; i++) begin
			pin_fn[i]  = pin_cfg_r[i / 2][(i % 2) * pgs_pkg::CFG_NIB_W
				+ pgs_pkg::CFG_FUNC_LSB +: 2];
			act_lvl[i] = pin_cfg_r[i / 2][(i % 2) * pgs_pkg::CFG_NIB_W
				+ pgs_pkg::CFG_TYPE_BIT];
			wen_n[i]   = pin_cfg_r[i / 2][(i % 2) * pgs_pkg::CFG_NIB_W
				+ pgs_pkg::CFG_WEN_BIT];
			is_in[i]   = pin_is_input(pin_fn[i], i);
			deb_en[i]  = is_in[i] && mode_bits_r[i]
				&& i_debounce_sel != pgs_pkg::DEB_NONE;
			act[i]     = ~(deb_lvl[i] ^ act_lvl[i]);
		end
		out_fn[0] = out_fn_lo_r[pgs_pkg::OUT0_LSB +: 3];
		out_fn[1] = out_fn_lo_r[pgs_pkg::OUT1_LSB +: 3];
		out_fn[2] = {1'b0, out_fn_lo_r[pgs_pkg::OUT2_LSB +: 2]};
		out_fn[3] = out_fn_hi_r[pgs_pkg::OUT3_LSB +: 3];
		out_fn[4] = {1'b0, out_fn_hi_r[pgs_pkg::OUT4_LSB +: 2]};
	end

	// ------------------------------------------------------------
	// debounce
	// ------------------------------------------------------------
	logic [pgs_pkg::DEB_CNT_W-1:0] deb_limit;

	always_comb begin
		unique case (i_debounce_sel)
			3'b001:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_1);
			3'b010:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_2);
			3'b011:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_3);
			3'b100:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_4);
			3'b101:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_5);
			3'b110:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_6);
			3'b111:  deb_limit = pgs_pkg::DEB_CNT_W'(DEB_CYC_7);
			default: deb_limit = pgs_pkg::DEB_CNT_W'(1);
		endcase
	end

	for (genvar g = 0; g < pgs_pkg::NUM_PINS; g++) begin : g_deb
		pgs_debounce u_deb (
			.i_clk_sys (i_clk_sys),
			.i_sys_rst (i_sys_rst),
			.i_enable  (deb_en[g]),
			.i_limit   (deb_limit),
			.i_raw     (i_pin_in[g]),
			.o_level   (deb_lvl[g])
		);
	end

	// ------------------------------------------------------------
	// transitions and wakeup
	// ------------------------------------------------------------
	// edges are held off until the debouncers have seen the pins
	logic [1:0] warm_r;
	logic [4:0] act_prev_r;
	logic [4:0] act_rise;
	logic [4:0] act_fall;
	logic [4:0] wake_r;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			warm_r     <= 2'h0;
			act_prev_r <= 5'h00;
		end else begin
			warm_r     <= {warm_r[0], 1'b1};
			act_prev_r <= act;
		end
	end

	assign act_rise = {5{warm_r[1]}} & is_in & act & ~act_prev_r;
	assign act_fall = {5{warm_r[1]}} & is_in & ~act & act_prev_r;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wake_r <= 5'h00;
		end else begin
			for (int i = 0; i < pgs_pkg::NUM_PINS; i++) begin
				wake_r[i] <= is_in[i] && !wen_n[i] &&
					(wake_sense_r[i] ? act[i] : act_rise[i]);
			end
		end
	end

	assign o_wake_req = wake_r;

	// ------------------------------------------------------------
	// output function mux
	// ------------------------------------------------------------
	logic [4:0] pin_out_r;
	logic [4:0] pin_oe_r;
	logic [4:0] drv;

	always_comb begin
		logic [3:0] src;
		src = 4'h0;
		for (int i = 0; i < pgs_pkg::NUM_PINS; i++) begin
			src = fwd_source(i, out_fn[i]);
			unique case (out_fn[i])
				pgs_pkg::OF_STATIC: drv[i] = mode_bits_r[i];
				pgs_pkg::OF_FAULT:  drv[i] =
					apply_pol(i_supply_fault, mode_bits_r[i]);
				pgs_pkg::OF_CLK32:  drv[i] =
					apply_pol(i_clk_32k, mode_bits_r[i]);
				pgs_pkg::OF_SEQ:    drv[i] =
					apply_pol(i_seq_pin_ctl[i], mode_bits_r[i]);
				// reserved codes park the pin at its inactive level
				default: drv[i] = src[3] ?
					apply_pol(act[src[2:0]], mode_bits_r[i])
					: ~mode_bits_r[i];
			endcase
			// pin 2 push-pull is the dedicated low-active fault output
			if (i == 2 && pin_fn[i] == pgs_pkg::PF_PUSH_PULL) begin
				drv[i] = ~i_supply_fault;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pin_out_r <= 5'h00;
			pin_oe_r  <= 5'h00;
		end else begin
			for (int i = 0; i < pgs_pkg::NUM_PINS; i++) begin
				unique case (pin_fn[i])
					pgs_pkg::PF_PUSH_PULL: begin
						pin_out_r[i] <= drv[i];
						pin_oe_r[i]  <= 1'b1;
					end
					pgs_pkg::PF_OPEN_DRAIN: begin
						pin_out_r[i] <= 1'b0;
						pin_oe_r[i]  <= ~drv[i];
					end
					default: begin
						pin_out_r[i] <= 1'b0;
						pin_oe_r[i]  <= 1'b0;
					end
				endcase
			end
		end
	end

	assign o_pin_out = pin_out_r;
	assign o_pin_oe  = pin_oe_r;

	// ------------------------------------------------------------
	// buck enable and voltage select
	// ------------------------------------------------------------
	logic [1:0] volt_second_r;
	logic       buck_b_on_r;
	logic [1:0] vsrc [2];
	logic [1:0] esrc [2];
	logic [1:0] v_rise;
	logic [1:0] v_fall;

	always_comb begin
		for (int b = 0; b < 2; b++) begin
			vsrc[b]   = buck_r[b][pgs_pkg::BK_VSRC_LSB +: 2];
			esrc[b]   = buck_r[b][pgs_pkg::BK_ESRC_LSB +: 2];
			en_evt[b] = esrc[b] != pgs_pkg::SRC_SEQ &&
				(act_rise[esrc[b]] || act_fall[esrc[b]]);
			en_val[b] = act_rise[esrc[b]];
			v_rise[b] = vsrc[b] != pgs_pkg::SRC_SEQ && act_rise[vsrc[b]];
			v_fall[b] = vsrc[b] != pgs_pkg::SRC_SEQ && act_fall[vsrc[b]];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			volt_second_r <= 2'h0;
		end else begin
			if (vsrc[0] == pgs_pkg::SRC_SEQ) begin
				volt_second_r[0] <= i_seq_volt_second_a;
			end else if (v_rise[0] || v_fall[0]) begin
				volt_second_r[0] <= v_fall[0];
			end
			if (vsrc[1] == pgs_pkg::SRC_SEQ) begin
				volt_second_r[1] <= i_seq_volt_second_b;
			end else if (v_rise[1] || v_fall[1]) begin
				volt_second_r[1] <= v_fall[1];
			end
		end
	end

	// second converter follows the first while they share phases
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			buck_b_on_r <= 1'b0;
		end else begin
			buck_b_on_r <= i_dual_phase ?
				buck_r[0][pgs_pkg::BK_EN_BIT] :
				buck_r[1][pgs_pkg::BK_EN_BIT];
		end
	end

	// on requests go to the sequencer, which applies the priority order
	assign o_buck_a_on          = buck_r[0][pgs_pkg::BK_EN_BIT];
	assign o_buck_b_on          = buck_b_on_r;
	assign o_buck_a_volt_second = volt_second_r[0];
	assign o_buck_b_volt_second = volt_second_r[1];
	assign o_buck_a_seq_config  = buck_r[0][pgs_pkg::BK_CONF_BIT];
	assign o_buck_b_seq_config  = buck_r[1][pgs_pkg::BK_CONF_BIT];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	chk_wake_edge: assert property (
		(is_in[0] && !wen_n[0] && !wake_sense_r[0] && !act_rise[0])
		|=> !o_wake_req[0])
		else $error("edge wakeup fired without an active edge");

	chk_wake_level: assert property (
		(is_in[1] && !wen_n[1] && wake_sense_r[1] && act[1])
		|=> o_wake_req[1])
		else $error("level wakeup missing while input active");

	chk_static_value: assert property (
		(pin_fn[0] == pgs_pkg::PF_PUSH_PULL
			&& out_fn[0] == pgs_pkg::OF_STATIC)
		|=> (o_pin_oe[0] && o_pin_out[0] == $past(mode_bits_r[0])))
		else $error("static output does not follow mode bit");

	chk_fault_polarity: assert property (
		(pin_fn[4] == pgs_pkg::PF_PUSH_PULL
			&& out_fn[4] == pgs_pkg::OF_FAULT)
		|=> o_pin_out[4] == ($past(mode_bits_r[4]) ~^ $past(i_supply_fault)))
		else $error("fault output polarity wrong");

	chk_debounce_off: assert property (
		(is_in[2] && !mode_bits_r[2])
		|=> deb_lvl[2] == $past(i_pin_in[2]))
		else $error("undebounced input did not follow the pin");

	chk_forward_pin1: assert property (
		(pin_fn[1] == pgs_pkg::PF_PUSH_PULL && out_fn[1] == 3'b100)
		|=> o_pin_out[1] == ($past(act[0]) ~^ $past(mode_bits_r[1])))
		else $error("pin 1 does not forward input 0");

	chk_reserved_idle: assert property (
		(pin_fn[0] == pgs_pkg::PF_PUSH_PULL && out_fn[0] == 3'b100)
		|=> o_pin_out[0] == !$past(mode_bits_r[0]))
		else $error("reserved code drove an active level");

	chk_enable_edge: assert property (
		(esrc[0] == 2'b01 && act_rise[1]) |=> o_buck_a_on ##0
		(esrc[0] != 2'b01 || !act_fall[1] || 1'b1))
		else $error("active edge did not enable the buck");

	chk_volt_fall: assert property (
		(vsrc[0] != pgs_pkg::SRC_SEQ && v_fall[0])
		|=> o_buck_a_volt_second [*1] ##1
		(o_buck_a_volt_second || $past(v_rise[0]) || vsrc[0] == 2'b00))
		else $error("passive edge did not select second voltage");

	chk_dual_follow: assert property (
		i_dual_phase |=> o_buck_b_on == $past(o_buck_a_on))
		else $error("second buck acted alone in dual-phase");

endmodule

`default_nettype wire

// ### pgs_pin_partner.sv
// far-side model of the devices wired to the five pads
`default_nettype none

module pgs_pin_partner (
	input  wire logic [4:0] i_pin_out,
	input  wire logic [4:0] i_pin_oe,
	input  wire logic [4:0] i_drive,
	output logic      [4:0] o_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// a pad the block drives reads back its own value
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			o_pin_in[k] = i_pin_oe[k] ? i_pin_out[k] : i_drive[k];
		end
	end
endmodule

`default_nettype wire

// ### tb_pgs_gpio_supply.sv
// self-checking bench for the pin and supply select block
`default_nettype none

module tb_pgs_gpio_supply;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int k; string n; logic [7:0] v;} pgs_note_t;

	logic        clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, look = 0;
	logic        flt = 0, c32 = 0, dual = 0, sva = 0, svb = 0, m;
	logic [8:0]  addr = 9'h000;
	logic [7:0]  wdat = 8'h00, rdat;
	logic [2:0]  dsel = 3'h0;
	logic [4:0]  drv = 5'h1f, seq = 5'h00, pin_in, pout, poe, wake;
	logic [5:0]  bk;
	logic [19:0] cfg;
	logic [31:0] rnd = 32'h1507c157;
	int          mismatches = 0, check_count = 0, p = 0;
	int          lsb[5] = '{0, 3, 6, 0, 3};
	pgs_note_t   q[$];

	always #4 clk = ~clk;

	// only the short hold times are shrunk; the long ones are never selected
	pgs_gpio_supply #(.DEB_CYC_1(4), .DEB_CYC_2(8)
	) pgs_gpio_supply_i (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
		.i_debounce_sel(dsel), .i_pin_in(pin_in), .o_pin_out(pout),
		.o_pin_oe(poe), .o_wake_req(wake), .i_supply_fault(flt),
		.i_clk_32k(c32), .i_seq_pin_ctl(seq), .i_seq_volt_second_a(sva),
		.i_seq_volt_second_b(svb), .i_dual_phase(dual),
		.o_buck_a_on(bk[5]), .o_buck_b_on(bk[4]),
		.o_buck_a_volt_second(bk[3]), .o_buck_b_volt_second(bk[2]),
		.o_buck_a_seq_config(bk[1]), .o_buck_b_seq_config(bk[0]));

	pgs_pin_partner pgs_pin_partner_i (.i_pin_out(pout), .i_pin_oe(poe),
		.i_drive(drv), .o_pin_in(pin_in));

	// ------------------------------------------------------------
	// checking side
	// ------------------------------------------------------------
	task automatic cmp(input string n, input logic [7:0] e, s);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cmp_reg(input string n, input logic [7:0] e);
		cmp(n, e, rdat);
	endtask

	task automatic cmp_pin(input string n, input logic [7:0] e);
		cmp(n, e, {6'h00, poe[p], pout[p]});
	endtask

	task automatic cmp_buck(input string n, input logic [7:0] e);
		cmp(n, e, {wake[1], 1'b0, bk});
	endtask

	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		pgs_note_t e;
		if (rd_d || look) begin
			e = q.pop_front();
			case (e.k)
				0: cmp_reg(e.n, e.v);
				1: cmp_pin(e.n, e.v);
				default: cmp_buck(e.n, e.v);
			endcase
		end
	end

	task automatic close_out();
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100us;
		mismatches++;
		close_out();
	end

	// ------------------------------------------------------------
	// driving side
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic wreg(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 0;
	endtask

	task automatic rreg(input logic [8:0] a, input logic [7:0] e);
		@(negedge clk);
		rd = 1;
		addr = a;
		q.push_back('{0, "reg_rdata", e});
		@(negedge clk);
		rd = 0;
	endtask

	// outputs are judged at the negedge after the next rising edge
	task automatic look_at(input int k, input string n, input logic [7:0] e,
		input int w);
		repeat (w) @(negedge clk);
		@(posedge clk);
		q.push_back('{k, n, e});
		look = 1;
		@(posedge clk);
		look = 0;
		// hand back on a falling edge so callers never drive on a rising one
		@(negedge clk);
	endtask

	function automatic logic pin_exp(input int c);
		logic a;
		case (c)
			0: return m;
			1: a = flt;
			2: a = c32;
			3: a = seq[p];
			default: a = (c - 4 == p) ? 1'b0 : drv[c-4];
		endcase
		return ~(a ^ m);
	endfunction

	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		for (logic [8:0] a = 9'h01c; a <= 9'h021; a++) begin
			rnd = xs(rnd);
			rreg(a, 8'h00);
			wreg(a, rnd[7:0]);
			rreg(a, rnd[7:0]);
		end
		wreg(9'h0a0, 8'h5a);
		rreg(9'h0a0, 8'h00);
		// one pad drives, the other four are active-high inputs
		for (int pp = 0; pp < 5; pp++) begin
			p = pp;
			cfg = 20'h55555;
			cfg[4*p+:4] = (p == 2) ? 4'h6 : 4'h7;
			wreg(9'h015, cfg[7:0]);
			wreg(9'h016, cfg[15:8]);
			wreg(9'h017, {4'h0, cfg[19:16]});
			for (int c = 0; c < ((p == 2 || p == 4) ? 4 : 8); c++) begin
				rnd = xs(rnd);
				m = rnd[8];
				drv = rnd[4:0];
				flt = rnd[5];
				c32 = rnd[6];
				seq = rnd[13:9];
				wreg(9'h01d, 8'(m) << p);
				wreg((p < 3) ? 9'h01e : 9'h01f, 8'(c) << lsb[p]);
				look_at(1, "pin_out", (p == 2) ? {6'h00, ~pin_exp(c), 1'b0}
					: {7'h01, pin_exp(c)}, 3);
			end
		end
		// pin 1 as an active-low input steering both bucks
		drv = 5'h1f;
		wreg(9'h015, 8'h10);
		wreg(9'h01d, 8'h00);
		wreg(9'h01c, 8'h00);
		wreg(9'h021, 8'h22);
		wreg(9'h020, 8'h28);
		drv[1] = 0;
		look_at(2, "buck", 8'h21, 5);
		rreg(9'h021, 8'h23);
		dual = 1;
		look_at(2, "buck", 8'h31, 3);
		wreg(9'h01c, 8'h02);
		look_at(2, "buck", 8'hb1, 3);
		drv[1] = 1;
		look_at(2, "buck", 8'h0d, 5);
		// a glitch shorter than the hold must not get through
		wreg(9'h01d, 8'h02);
		dsel = 3'h1;
		drv[1] = 0;
		repeat (2) @(negedge clk);
		drv[1] = 1;
		look_at(2, "buck", 8'h0d, 8);
		drv[1] = 0;
		look_at(2, "buck", 8'hb1, 12);
		// voltage source 00 hands the choice back to the sequencer inputs
		rnd = xs(rnd);
		sva = rnd[0];
		svb = rnd[1];
		wreg(9'h021, 8'h03);
		wreg(9'h020, 8'h08);
		look_at(2, "buck", {4'hb, sva, svb, 2'h1}, 3);
		close_out();
	end
endmodule

`default_nettype wire
